// *** gpcr_params.svh ***
`ifndef GPCR_PARAMS_SVH
`define GPCR_PARAMS_SVH

// Register offsets on the serial control port
`define GPCR_OFS_IDENT   7'h48
`define GPCR_OFS_TRIM    7'h49
`define GPCR_OFS_PINCTL  7'h4a
`define GPCR_OFS_PINLVL  7'h4b
`define GPCR_OFS_PWSCR   7'h4c
`define GPCR_OFS_PWSSR   7'h4d
`define GPCR_OFS_USBFCR  7'h4e
`define GPCR_OFS_USBFST  7'h4f

// Field positions
`define GPCR_PIN_DIR_LSB 0
`define GPCR_PIN_DO_LSB  4
`define GPCR_PWS_CLR1    2
`define GPCR_PWS_CLR2    3
`define GPCR_SR_FLAT1    2
`define GPCR_SR_FLAT2    3
`define GPCR_USB_CLR     0
`define GPCR_USB_SLEEP   1

// Reset values
`define GPCR_PINCTL_RST  8'h00
`define GPCR_TRIM_RST    8'h00
`define GPCR_FORCE_RST   2'h0

// Selected-source codes, shared by override and status for 01, 10 and 11; override 00 is automatic, not off
`define GPCR_SRC_OFF     2'h0
`define GPCR_SRC_PSU     2'h1
`define GPCR_SRC_BAT2    2'h2
`define GPCR_SRC_BAT1    2'h3

// Serial frame: 8 command bits then 8 data bits
`define GPCR_CMD_LAST    4'h7
`define GPCR_FRAME_LAST  4'hf

// Rail levels in mV, packed {code 11, code 10, code 01, code 00}
`define GPCR_R1_LO_MV    {12'h5dc, 12'h44c, 12'h514, 12'h4b0}
`define GPCR_R1_HI_MV    {12'h672, 12'h6a4, 12'h708, 12'h6d6}
`define GPCR_R2_LO_MV    {12'h6a4, 12'h6d6, 12'h73a, 12'h708}
`define GPCR_R2_HI_MV    {12'h8fc, 12'h960, 12'ha28, 12'h9c4}
`define GPCR_R3_MV       {12'hd48, 12'hc80, 12'hc1c, 12'hce4}
`define GPCR_R4_MV       {12'h44c, 12'h366, 12'h4b0, 12'h384}

`endif

// *** gpcr_pkg.sv ***
`default_nettype none
package gpcr_pkg;

    typedef enum logic [2:0] {
        GPCR_S_IDLE = 3'b001,
        GPCR_S_CMD  = 3'b010,
        GPCR_S_DATA = 3'b100
    } gpcr_spi_state_t;

    typedef logic [6:0]  gpcr_addr_t;
    typedef logic [11:0] gpcr_mv_t;
    typedef logic [47:0] gpcr_mv_table_t;

endpackage
`default_nettype wire

// *** gpcr_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpcr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    // Asynchronous levels in, synchronised out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule
`default_nettype wire

// *** gpcr_rail_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "gpcr_params.svh"
module gpcr_rail_decode
    import gpcr_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // Trim codes and range selects
    input  wire logic [7:0] trim_i,
    input  wire logic       rail1_high_range_sel_i,
    input  wire logic       rail2_high_range_sel_i,
    // Decoded rail levels in mV
    output gpcr_mv_t        rail1_mv_o,
    output gpcr_mv_t        rail2_mv_o,
    output gpcr_mv_t        rail3_mv_o,
    output gpcr_mv_t        rail4_mv_o
);

    function automatic gpcr_mv_t pick(input gpcr_mv_table_t tbl, input logic [1:0] code);
        // Six bits so the offset of code 11 does not wrap
        return tbl[{1'b0, code, 3'h0} + {2'b00, code, 2'h0} +: 12];
    endfunction

    gpcr_mv_t next_rail1_mv;
    gpcr_mv_t next_rail2_mv;
    gpcr_mv_t next_rail3_mv;
    gpcr_mv_t next_rail4_mv;

    always_comb begin
        next_rail1_mv = pick(rail1_high_range_sel_i ? `GPCR_R1_HI_MV : `GPCR_R1_LO_MV,
                             trim_i[1:0]); // see RULE5
        next_rail2_mv = pick(rail2_high_range_sel_i ? `GPCR_R2_HI_MV : `GPCR_R2_LO_MV,
                             trim_i[3:2]); // see RULE6
        next_rail3_mv = pick(`GPCR_R3_MV, trim_i[5:4]); // see RULE7
        next_rail4_mv = pick(`GPCR_R4_MV, trim_i[7:6]); // see RULE8
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rail1_mv_o <= 12'h4b0;
            rail2_mv_o <= 12'h708;
            rail3_mv_o <= 12'hce4;
            rail4_mv_o <= 12'h384;
        end else begin
            rail1_mv_o <= next_rail1_mv;
            rail2_mv_o <= next_rail2_mv;
            rail3_mv_o <= next_rail3_mv;
            rail4_mv_o <= next_rail4_mv;
        end
    end

    chk_rail1_top_code: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE5
        (trim_i[1:0] == 2'h3) |=> rail1_mv_o == ($past(rail1_high_range_sel_i) ? 12'h672 : 12'h5dc))
        else $error("rail 1 code 11 decoded wrongly");
    chk_rail2_mid_code: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE6
        (trim_i[3:2] == 2'h2) |=> rail2_mv_o == ($past(rail2_high_range_sel_i) ? 12'h960 : 12'h6d6))
        else $error("rail 2 code 10 decoded wrongly");
    chk_rail3_default: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE7
        (trim_i[5:4] == 2'h0) |=> rail3_mv_o == 12'hce4)
        else $error("rail 3 default level wrong");
    chk_rail4_low_code: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE8
        (trim_i[7:6] == 2'h2) |=> rail4_mv_o == 12'h366)
        else $error("rail 4 code 10 decoded wrongly");

endmodule
`default_nettype wire

// *** gpcr_regs.sv ***
// What this block does
// RULE1: Identity register reads fixed maker code high, revision low; writes ignored.
// RULE2: Pin level register reads the four strap pin levels in bits 3..0.
// RULE3: Pin control bits 3..0 set direction: 0 input, 1 output.
// RULE4: Pin control bits 7..4 give the driven level, only for output pins.
// RULE5: Rail 1 code decodes to 1.2/1.3/1.1/1.5V, or 1.75/1.80/1.70/1.65V high range.
// RULE6: Rail 2 code decodes to 1.80/1.85/1.75/1.70V, or 2.50/2.60/2.40/2.30V high range.
// RULE7: Rail 3 code decodes to 3.3/3.1/3.2/3.4V, 00 default.
// RULE8: Rail 4 code decodes to 0.9/1.20/0.87/1.10V, 00 default.
// RULE9: Override field: 00 automatic default, 01 PSU, 10 battery 2, 11 battery 1.
// RULE10: Writing 1 to a flat-clear bit clears that flat flag; 0 does nothing.
// RULE11: Selected-source status: 00 off, 01 PSU, 10 battery 2, 11 battery 1.
// RULE12: Flat flags reset 0, latch when selected battery goes flat, exclude it.
// RULE13: USB precharge flag reads 1 once USB precharged the battery stand-alone.
// RULE14: Writing 1 to flag control bit 0 clears the USB precharge flag.
// RULE15: Writing 1 to flag control bit 1 requests the USB sleep state machine.
// RULE16: Selected-source status is readable over the serial control port.
// RULE17: Unused bits read 0 and ignore writes.
`timescale 1ns/1ns
`default_nettype none
`include "gpcr_params.svh"
module gpcr_regs
    import gpcr_pkg::*;
#(
    parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
    parameter logic [3:0] REV_CODE   = 4'h1  // Arbitrary value
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    // Serial control port
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_n_o,
    // Strap pins
    input  wire logic [3:0] strap_pin_i,
    output logic      [3:0] strap_pin_o,
    output logic      [3:0] strap_pin_oe_n_o,
    // Power switch
    input  wire logic [1:0] selected_source_i,
    input  wire logic       bat1_flat_i,
    input  wire logic       bat2_flat_i,
    output logic      [1:0] source_override_o,
    output logic            bat1_excluded_o,
    output logic            bat2_excluded_o,
    // USB precharge and sleep
    input  wire logic       usb_precharge_done_i,
    output logic            usb_sleep_request_o,
    // Rails
    input  wire logic       rail1_high_range_sel_i,
    input  wire logic       rail2_high_range_sel_i,
    output gpcr_mv_t        rail1_mv_o,
    output gpcr_mv_t        rail2_mv_o,
    output gpcr_mv_t        rail3_mv_o,
    output gpcr_mv_t        rail4_mv_o
);

    function automatic logic wr_hit(input logic en, input gpcr_addr_t a, input gpcr_addr_t ofs);
        return en && (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [12:0] pin_s;
    logic        sclk_s;
    logic        cs_n_s;
    logic        mosi_s;
    logic [3:0]  strap_s;
    logic        flat1_s;
    logic        flat2_s;
    logic [1:0]  sel_s;
    logic        hi1_s;
    logic        hi2_s;

    gpcr_sync #(
        .W          (13)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    ({rail2_high_range_sel_i, rail1_high_range_sel_i, selected_source_i,
                      bat2_flat_i, bat1_flat_i, strap_pin_i, spi_mosi_i, spi_cs_n_i,
                      spi_sclk_i}),
        .sync_o     (pin_s)
    );

    assign sclk_s  = pin_s[0];
    assign cs_n_s  = pin_s[1];
    assign mosi_s  = pin_s[2];
    assign strap_s = pin_s[6:3];
    assign flat1_s = pin_s[7];
    assign flat2_s = pin_s[8];
    assign sel_s   = pin_s[10:9];
    assign hi1_s   = pin_s[11];
    assign hi2_s   = pin_s[12];

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage declarations

    logic [7:0] pinctl;
    logic [7:0] trim;
    logic [1:0] force_src;
    logic       flat1;
    logic       flat2;
    logic       usb_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame engine

    gpcr_spi_state_t state;
    gpcr_spi_state_t next_state;
    logic [3:0]      bit_cnt;
    logic [3:0]      next_bit_cnt;
    logic [6:0]      rx;
    logic [6:0]      next_rx;
    logic [7:0]      tx;
    logic [7:0]      next_tx;
    logic            rd;
    logic            next_rd;
    logic            sclk_q;
    logic            next_miso;
    logic            next_miso_oe_n;
    logic            wr_en;
    logic            next_wr_en;
    gpcr_addr_t      wr_addr;
    gpcr_addr_t      next_wr_addr;
    logic [7:0]      wr_data;
    logic [7:0]      next_wr_data;
    gpcr_addr_t      cmd_addr;
    logic [7:0]      rd_word;
    logic            sclk_rise;
    logic            sclk_fall;

    assign sclk_rise = sclk_s && !sclk_q;
    assign sclk_fall = !sclk_s && sclk_q;
    assign cmd_addr  = {rx[5:0], mosi_s};

    // Read mux, sampled as the last command bit arrives
    always_comb begin
        rd_word = 8'h00;
        unique case (cmd_addr)
            `GPCR_OFS_IDENT:  rd_word = {MAKER_CODE, REV_CODE}; // see RULE1
            `GPCR_OFS_TRIM:   rd_word = trim;
            `GPCR_OFS_PINCTL: rd_word = pinctl;
            `GPCR_OFS_PINLVL: rd_word = {4'h0, strap_s}; // see RULE2
            `GPCR_OFS_PWSCR:  rd_word = {6'h00, force_src};
            `GPCR_OFS_PWSSR:  rd_word = {4'h0, flat2, flat1, sel_s}; // see RULE11 see RULE16
            `GPCR_OFS_USBFST: rd_word = {7'h00, usb_flag}; // see RULE13
            default:          rd_word = 8'h00; // see RULE17
        endcase
    end

    always_comb begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_rx        = rx;
        next_tx        = tx;
        next_rd        = rd;
        next_miso      = spi_miso_o;
        next_wr_en     = 1'b0;
        next_wr_addr   = wr_addr;
        next_wr_data   = wr_data;
        if (cs_n_s) begin
            next_state   = GPCR_S_IDLE;
            next_bit_cnt = 4'h0;
            next_rd      = 1'b0;
        end else if (sclk_rise) begin
            next_rx      = {rx[5:0], mosi_s};
            next_bit_cnt = bit_cnt + 4'h1;
            unique case (state)
                GPCR_S_IDLE, GPCR_S_CMD: begin
                    next_state = GPCR_S_CMD;
                    if (bit_cnt == `GPCR_CMD_LAST) begin
                        next_state   = GPCR_S_DATA;
                        next_rd      = rx[6];
                        next_wr_addr = cmd_addr;
                        next_tx      = rd_word;
                    end
                end
                GPCR_S_DATA: begin
                    if (bit_cnt == `GPCR_FRAME_LAST) begin
                        next_state = GPCR_S_CMD;
                        next_rd    = 1'b0;
                        next_wr_en = !rd;
                        next_wr_data = {rx, mosi_s};
                    end
                end
            endcase
        end else if (sclk_fall && state == GPCR_S_DATA && rd) begin
            next_miso = tx[7];
            next_tx   = {tx[6:0], 1'b0};
        end
        next_miso_oe_n = !(next_state == GPCR_S_DATA && next_rd);
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state           <= GPCR_S_IDLE;
            bit_cnt         <= 4'h0;
            rx              <= 7'h00;
            tx              <= 8'h00;
            rd              <= 1'b0;
            sclk_q          <= 1'b0;
            spi_miso_o      <= 1'b0;
            spi_miso_oe_n_o <= 1'b1;
            wr_en           <= 1'b0;
            wr_addr         <= 7'h00;
            wr_data         <= 8'h00;
        end else begin
            state           <= next_state;
            bit_cnt         <= next_bit_cnt;
            rx              <= next_rx;
            tx              <= next_tx;
            rd              <= next_rd;
            sclk_q          <= sclk_s;
            spi_miso_o      <= next_miso;
            spi_miso_oe_n_o <= next_miso_oe_n;
            wr_en           <= next_wr_en;
            wr_addr         <= next_wr_addr;
            wr_data         <= next_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] next_pinctl;
    logic [7:0] next_trim;
    logic [1:0] next_force;
    logic       next_flat1;
    logic       next_flat2;
    logic       next_usb_flag;
    logic       next_sleep;
    logic [3:0] next_pin_oe_n;
    logic       set1;
    logic       set2;
    logic       clr1;
    logic       clr2;
    logic       usb_clr;

    always_comb begin
        next_pinctl = pinctl;
        next_trim   = trim;
        next_force  = force_src;
        if (wr_hit(wr_en, wr_addr, `GPCR_OFS_PINCTL)) begin
            next_pinctl = wr_data; // see RULE3 see RULE4
        end
        if (wr_hit(wr_en, wr_addr, `GPCR_OFS_TRIM)) begin
            next_trim = wr_data;
        end
        if (wr_hit(wr_en, wr_addr, `GPCR_OFS_PWSCR)) begin
            next_force = wr_data[1:0]; // see RULE9
        end
        // A flag only latches for the battery that is actually in use
        set1 = flat1_s && (sel_s == `GPCR_SRC_BAT1);
        set2 = flat2_s && (sel_s == `GPCR_SRC_BAT2);
        clr1 = wr_hit(wr_en, wr_addr, `GPCR_OFS_PWSCR) && wr_data[`GPCR_PWS_CLR1];
        clr2 = wr_hit(wr_en, wr_addr, `GPCR_OFS_PWSCR) && wr_data[`GPCR_PWS_CLR2];
        usb_clr = wr_hit(wr_en, wr_addr, `GPCR_OFS_USBFCR) && wr_data[`GPCR_USB_CLR];
        // Set beats clear so an event in the clearing cycle is kept
        next_flat1    = set1 || (flat1 && !clr1); // see RULE10 see RULE12
        next_flat2    = set2 || (flat2 && !clr2); // see RULE10 see RULE12
        next_usb_flag = usb_precharge_done_i || (usb_flag && !usb_clr); // see RULE13 see RULE14
        next_sleep    = wr_hit(wr_en, wr_addr, `GPCR_OFS_USBFCR)
                        && wr_data[`GPCR_USB_SLEEP]; // see RULE15
        next_pin_oe_n = ~next_pinctl[`GPCR_PIN_DIR_LSB +: 4]; // see RULE3
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pinctl              <= `GPCR_PINCTL_RST;
            trim                <= `GPCR_TRIM_RST;
            force_src           <= `GPCR_FORCE_RST;
            flat1               <= 1'b0;
            flat2               <= 1'b0;
            usb_flag            <= 1'b0;
            usb_sleep_request_o <= 1'b0;
            strap_pin_oe_n_o    <= 4'hf;
        end else begin
            pinctl              <= next_pinctl;
            trim                <= next_trim;
            force_src           <= next_force;
            flat1               <= next_flat1;
            flat2               <= next_flat2;
            usb_flag            <= next_usb_flag;
            usb_sleep_request_o <= next_sleep;
            strap_pin_oe_n_o    <= next_pin_oe_n;
        end
    end

    assign strap_pin_o       = pinctl[`GPCR_PIN_DO_LSB +: 4]; // see RULE4
    assign source_override_o = force_src;
    assign bat1_excluded_o   = flat1; // see RULE12
    assign bat2_excluded_o   = flat2;

    gpcr_rail_decode u_rails (
        .core_clk_i             (core_clk_i),
        .reset_i                (reset_i),
        .trim_i                 (trim),
        .rail1_high_range_sel_i (hi1_s),
        .rail2_high_range_sel_i (hi2_s),
        .rail1_mv_o             (rail1_mv_o),
        .rail2_mv_o             (rail2_mv_o),
        .rail3_mv_o             (rail3_mv_o),
        .rail4_mv_o             (rail4_mv_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic load_cmd;
    assign load_cmd = !cs_n_s && sclk_rise && state != GPCR_S_DATA && bit_cnt == `GPCR_CMD_LAST;

    sequence seq_write(gpcr_addr_t ofs, int bitn);
        wr_en && wr_addr == ofs && wr_data[bitn];
    endsequence

    sequence seq_pulse_once;
        usb_sleep_request_o ##1 !usb_sleep_request_o;
    endsequence

    chk_ident_load: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE1
        load_cmd && cmd_addr == `GPCR_OFS_IDENT |=> tx == {MAKER_CODE, REV_CODE})
        else $error("identity read does not return fixed code");
    chk_levels_load: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE2
        load_cmd && cmd_addr == `GPCR_OFS_PINLVL |=> tx == {4'h0, $past(strap_s)})
        else $error("pin level read wrong");
    chk_pin_dir: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE3
        wr_en && wr_addr == `GPCR_OFS_PINCTL |=> strap_pin_oe_n_o == ~$past(wr_data[3:0]))
        else $error("pin direction not taken from write");
    chk_pin_level: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE4
        wr_en && wr_addr == `GPCR_OFS_PINCTL |=> strap_pin_o == $past(wr_data[7:4]))
        else $error("pin drive level not taken from write");
    chk_override_write: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE9
        wr_en && wr_addr == `GPCR_OFS_PWSCR |=> source_override_o == $past(wr_data[1:0]))
        else $error("override field not updated");
    chk_flat_clear: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE10
        seq_write(`GPCR_OFS_PWSCR, `GPCR_PWS_CLR1) and !set1 |=> !bat1_excluded_o)
        else $error("flat flag 1 not cleared");
    chk_flat_latch: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE12
        flat2_s && sel_s == `GPCR_SRC_BAT2 |=> bat2_excluded_o)
        else $error("flat flag 2 not latched");
    chk_status_load: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE16
        load_cmd && cmd_addr == `GPCR_OFS_PWSSR |=> tx[7:4] == 4'h0 && tx[1:0] == $past(sel_s))
        else $error("status read wrong");
    chk_usb_flag: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE13
        usb_precharge_done_i |=> usb_flag)
        else $error("precharge flag not set");
    chk_usb_clear: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE14
        seq_write(`GPCR_OFS_USBFCR, `GPCR_USB_CLR) and !usb_precharge_done_i |=> !usb_flag)
        else $error("precharge flag not cleared");
    chk_sleep_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i) // see RULE15
        seq_write(`GPCR_OFS_USBFCR, `GPCR_USB_SLEEP) |=> seq_pulse_once)
        else $error("sleep request not a single pulse");

endmodule
`default_nettype wire

// *** gpcr_spi_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module gpcr_spi_host (
    // Clock
    input  wire logic       core_clk_i,
    // Serial port
    input  wire logic       miso_i,
    input  wire logic       miso_oe_n_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            mosi_o,
    // Read results
    output logic            rd_done_o,
    output logic      [7:0] rd_data_o
);
    // A released line shows the inverse of its last level, never a held copy
    wire logic line_w = miso_oe_n_i ? ~miso_i : miso_i;

    initial begin
        sclk_o    = 1'b0;
        cs_n_o    = 1'b1;
        mosi_o    = 1'b0;
        rd_done_o = 1'b0;
        rd_data_o = 8'h00;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Mode 0 frame, 64 ns serial clock; fewer than 16 bits aborts the frame
    task automatic xfer(input logic rd, input logic [6:0] adr, input logic [7:0] dat,
                        input int nbits);
        logic [15:0] frm;
        frm = {rd, adr, dat};
        wt(1);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 16 - nbits; i--) begin
            mosi_o = frm[i];
            wt(4);
            sclk_o = 1'b1;
            // Sampled just after the rise: enable drops soon after the last one
            wt(1);
            if (i < 8) rd_data_o[i] = line_w;
            wt(3);
            sclk_o = 1'b0;
        end
        wt(4);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        if (rd && nbits == 16) begin
            rd_done_o = 1'b1;
            wt(1);
            rd_done_o = 1'b0;
        end
        wt(8);
    endtask
endmodule
`default_nettype wire

// *** tb_general_purpose_control_registers.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "gpcr_params.svh"
module tb_general_purpose_control_registers
    import gpcr_pkg::*;
;
    localparam logic [3:0] MAKER = 4'h9; // Arbitrary value
    localparam logic [3:0] REV   = 4'h3; // Arbitrary value
    localparam logic [11:0] R1L [4] = '{12'h4b0, 12'h514, 12'h44c, 12'h5dc};
    localparam logic [11:0] R1H [4] = '{12'h6d6, 12'h708, 12'h6a4, 12'h672};
    localparam logic [11:0] R2L [4] = '{12'h708, 12'h73a, 12'h6d6, 12'h6a4};
    localparam logic [11:0] R2H [4] = '{12'h9c4, 12'ha28, 12'h960, 12'h8fc};
    localparam logic [11:0] R3  [4] = '{12'hce4, 12'hc1c, 12'hc80, 12'hd48};
    localparam logic [11:0] R4  [4] = '{12'h384, 12'h4b0, 12'h366, 12'h44c};

    logic       core_clk_i, reset_i, sclk, cs_n, mosi, miso, miso_oe_n, rd_done;
    logic       flat1, flat2, excl1, excl2, usb_done, sleep, rsel1, rsel2;
    logic [7:0] rd_data;
    logic [3:0] ext_pin, pin_lvl, pin_drv, pin_oe_n;
    logic [1:0] sel_src, ovr;
    gpcr_mv_t   mv1, mv2, mv3, mv4;
    logic [7:0] exp_q [$];
    int         failures, n_checks, n_sleep;

    // Strap wire: the device wins where it drives, the board elsewhere
    assign pin_lvl = (pin_drv & ~pin_oe_n) | (ext_pin & pin_oe_n);

    gpcr_regs #(.MAKER_CODE(MAKER), .REV_CODE(REV)) u_gpcr_regs (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n),
        .strap_pin_i(pin_lvl), .strap_pin_o(pin_drv), .strap_pin_oe_n_o(pin_oe_n),
        .selected_source_i(sel_src), .bat1_flat_i(flat1), .bat2_flat_i(flat2),
        .source_override_o(ovr), .bat1_excluded_o(excl1), .bat2_excluded_o(excl2),
        .usb_precharge_done_i(usb_done), .usb_sleep_request_o(sleep),
        .rail1_high_range_sel_i(rsel1), .rail2_high_range_sel_i(rsel2),
        .rail1_mv_o(mv1), .rail2_mv_o(mv2), .rail3_mv_o(mv3), .rail4_mv_o(mv4));

    gpcr_spi_host u_gpcr_spi_host (
        .core_clk_i(core_clk_i), .miso_i(miso), .miso_oe_n_i(miso_oe_n), .sclk_o(sclk),
        .cs_n_o(cs_n), .mosi_o(mosi), .rd_done_o(rd_done), .rd_data_o(rd_data));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        n_checks++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_gpcr_spi_host.xfer(1'b0, a, d, 16);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_gpcr_spi_host.xfer(1'b1, a, 8'h00, 16);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge rd_done) begin
        if (exp_q.size() == 0) check(12'h000, 12'hfff);
        else check({4'h0, rd_data}, {4'h0, exp_q.pop_front()});
    end

    // Counted on the falling edge, half a cycle after the launching edge, so the pulse is seen exactly once
    always @(negedge core_clk_i) begin
        if (sleep === 1'b1) n_sleep++;
    end

    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (100000) @(posedge core_clk_i);
        failures++;
        conclude();
    end

    initial begin
        {reset_i, flat1, flat2, usb_done, rsel1, rsel2, sel_src} = 8'h80;
        ext_pin = 4'($urandom(26));
        // Synchronous reset clears the synchronisers in a single edge
        cyc(2);
        reset_i = 1'b0;
        cyc(4);
        check({excl2, excl1, ovr, pin_oe_n, pin_drv}, 12'h0f0);
        rd(`GPCR_OFS_IDENT, {MAKER, REV});
        wr(`GPCR_OFS_IDENT, 8'h00);
        rd(`GPCR_OFS_IDENT, {MAKER, REV});
        wr(`GPCR_OFS_PINCTL, 8'h35);
        check({4'h0, pin_drv, pin_oe_n}, 12'h03a);
        rd(`GPCR_OFS_PINCTL, 8'h35);
        rd(`GPCR_OFS_PINLVL, {4'h0, 4'h1 | (ext_pin & 4'ha)});
        for (int i = 0; i < 8; i++) begin
            {rsel2, rsel1} = {2{i[2]}};
            wr(`GPCR_OFS_TRIM, {i[1:0] + 2'd3, i[1:0] + 2'd2, i[1:0] + 2'd1, i[1:0]});
            check(mv1, i[2] ? R1H[i[1:0]] : R1L[i[1:0]]);
            check(mv2, i[2] ? R2H[2'(i + 1)] : R2L[2'(i + 1)]);
            check(mv3, R3[2'(i + 2)]);
            check(mv4, R4[2'(i + 3)]);
        end
        rd(`GPCR_OFS_TRIM, 8'h93);
        for (int i = 0; i < 4; i++) begin
            sel_src = 2'(i);
            wr(`GPCR_OFS_PWSCR, 8'(i));
            check(12'(ovr), 12'(i));
            rd(`GPCR_OFS_PWSCR, 8'(i));
            rd(`GPCR_OFS_PWSSR, 8'(i));
        end
        for (int b = 0; b < 2; b++) begin
            sel_src = b ? 2'h2 : 2'h3;
            {flat2, flat1} = 2'b11;
            cyc(6);
            {flat2, flat1} = 2'b00;
            wr(`GPCR_OFS_PWSCR, b ? 8'h04 : 8'h08);
            check({10'h0, excl2, excl1}, b ? 12'h2 : 12'h1);
            rd(`GPCR_OFS_PWSSR, b ? 8'h0a : 8'h07);
            wr(`GPCR_OFS_PWSCR, b ? 8'h08 : 8'h04);
            check({10'h0, excl2, excl1}, 12'h0);
        end
        usb_done = 1'b1;
        cyc(1);
        usb_done = 1'b0;
        rd(`GPCR_OFS_USBFST, 8'h01);
        wr(`GPCR_OFS_USBFCR, 8'h00);
        rd(`GPCR_OFS_USBFST, 8'h01);
        check(12'(n_sleep), 12'h0);
        wr(`GPCR_OFS_USBFCR, 8'h02);
        check(12'(n_sleep), 12'h1);
        wr(`GPCR_OFS_USBFCR, 8'h01);
        rd(`GPCR_OFS_USBFST, 8'h00);
        rd(`GPCR_OFS_USBFCR, 8'h00);
        check(12'(n_sleep), 12'h1);
        u_gpcr_spi_host.xfer(1'b0, `GPCR_OFS_PINCTL, 8'hff, 12);
        rd(`GPCR_OFS_PINCTL, 8'h35);
        rd(7'h10, 8'h00);
        check(12'(exp_q.size()), 12'h0);
        conclude();
    end
endmodule
`default_nettype wire
